// file: hv_port_defines.vh
`ifndef HV_PORT_DEFINES_VH
`define HV_PORT_DEFINES_VH

// Register addresses on the CPU register write port
`define ADDR_W              6
`define ADDR_PORT_MODE_A    6'h04
`define ADDR_PORT_MODE_B    6'h24
`define ADDR_MISC_PIN_CTRL  6'h0c

// Register widths and reset values
`define REG_W               4
`define REG_RESET           4'h0
`define NUM_PINS            9
`define PIN_IDX_W           4
`define LATCH_RESET         9'h000

// Field positions
`define ALARM_SEL_BIT       3
`define STOP_REL_SEL_BIT    3
`define EVENT_SEL_BIT       2
`define IRQ1_SEL_BIT        1
`define IRQ0_SEL_BIT        0
`define PULLUP_EN_BIT       3
`define SO_OD_SEL_BIT       2

// Pins carrying shared functions
`define PIN_IRQ0            0
`define PIN_IRQ1            1
`define PIN_EVENT           2
`define PIN_ALARM           3
`define PIN_STOP_REL        4

// Power states
`define PWR_W               2
`define PWR_RUN             2'h0
`define PWR_STANDBY         2'h1
`define PWR_STOP            2'h2

`endif

// file: bit_latch_file.v
`timescale 1ns/1ps
`include "hv_port_defines.vh"
// Nine single-bit output latches with set, clear and stop clear
module bit_latch_file (
    // Clock and reset
    input  wire                    mclk,
    input  wire                    arst_n,
    // Control
    input  wire                    stop_clear,
    input  wire                    set_req,
    input  wire                    clear_req,
    input  wire [`PIN_IDX_W-1:0]   pin_sel,
    // Latch contents
    output wire [`NUM_PINS-1:0]    latch
);

    genvar i;
    generate
        for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_latch
            reg bit_q;
            always @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    bit_q <= 1'b0;
                end else if (stop_clear) begin
                    bit_q <= 1'b0;
                end else if (pin_sel == i) begin
                    if (set_req) begin
                        bit_q <= 1'b1;
                    end else if (clear_req) begin
                        bit_q <= 1'b0;
                    end
                end
            end
            assign latch[i] = bit_q;
        end
    endgenerate

endmodule // bit_latch_file

// file: mode_regs.v
`timescale 1ns/1ps
`include "hv_port_defines.vh"
// Write-only mode registers, cleared at reset and on stop entry
module mode_regs (
    // Clock and reset
    input  wire                    mclk,
    input  wire                    arst_n,
    // Write port
    input  wire                    stop_clear,
    input  wire                    reg_wr,
    input  wire [`ADDR_W-1:0]      reg_addr,
    input  wire [`REG_W-1:0]       reg_wdata,
    // Register contents
    output reg  [`REG_W-1:0]       port_mode_a,
    output reg  [`REG_W-1:0]       port_mode_b,
    output reg  [`REG_W-1:0]       misc_pin_control
);

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port_mode_a      <= `REG_RESET;
            port_mode_b      <= `REG_RESET;
            misc_pin_control <= `REG_RESET;
        end else if (stop_clear) begin
            port_mode_a      <= `REG_RESET;
            port_mode_b      <= `REG_RESET;
            misc_pin_control <= `REG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_PORT_MODE_A) begin
                port_mode_a <= reg_wdata;
            end else if (reg_addr == `ADDR_PORT_MODE_B) begin
                port_mode_b <= reg_wdata;
            end else if (reg_addr == `ADDR_MISC_PIN_CTRL) begin
                misc_pin_control <= reg_wdata;
            end
        end
    end

endmodule // mode_regs

// file: high_voltage_bit_port_ctrl.v
`timescale 1ns/1ps
`include "hv_port_defines.vh"

// Functional notes
// - Pull-up enable 0: all pull-ups off
// - Pull-up enable 1: pull-up where latch 1
// - Open-drain select 0: serial out push-pull
// - Open-drain select 1: serial out high-side off
// - Stop resets selections, halts, floats pins
// - Other low-power modes keep halt high
// - Standby holds plain outputs, running peripherals
// - Standby freezes stopped peripheral outputs
// - Nine pins, each with output latch
// - Set writes 1, clear writes 0
// - Bit test returns pin input level
// - Latches cleared on reset and stop
// - Mode A bit 3 routes alarm pin
// - Mode B bit 3 selects stop release
// - Mode B bit 2 selects timer event
// - Mode B bit 1 selects irq1 input
// - Mode B bit 0 selects irq0 input
// - Mode B is 4-bit write-only, reset 0
// - Latch 1 drives high, 0 floats
module high_voltage_bit_port_ctrl (
    // Clock and reset
    input  wire                    mclk,
    input  wire                    arst_n,
    // Power state from the system controller
    input  wire [`PWR_W-1:0]       power_mode,
    // CPU bit instructions
    input  wire                    bit_set_op,
    input  wire                    bit_clear_op,
    input  wire                    bit_test_op,
    input  wire [`PIN_IDX_W-1:0]   pin_index,
    output reg                     bit_test_result,
    // CPU register writes
    input  wire                    reg_wr,
    input  wire [`ADDR_W-1:0]      reg_addr,
    input  wire [`REG_W-1:0]       reg_wdata,
    // High-voltage port pins
    input  wire [`NUM_PINS-1:0]    pin_in,
    output wire [`NUM_PINS-1:0]    pin_out,
    output wire [`NUM_PINS-1:0]    pin_oe,
    // Peripheral side
    input  wire                    alarm_out,
    input  wire                    alarm_runs_in_standby,
    output wire                    ext_irq0_n,
    output wire                    ext_irq1_n,
    output wire                    timer_b_event_in,
    output wire                    stop_release_n,
    // Standard-voltage pin controls
    input  wire [`NUM_PINS-1:0]    std_pin_latch,
    output wire [`NUM_PINS-1:0]    std_pullup_on,
    input  wire                    serial_out_data,
    output wire                    serial_out_high_on,
    output wire                    serial_out_low_on,
    // Internal halt and mode visibility
    output wire                    halt_n,
    output wire                    pullup_enable,
    output wire                    serial_out_open_drain_sel
);

    wire [`REG_W-1:0]     port_mode_a;
    wire [`REG_W-1:0]     port_mode_b;
    wire [`REG_W-1:0]     misc_pin_control;
    wire [`NUM_PINS-1:0]  output_latch;
    wire                  in_stop;
    wire                  in_standby;
    wire                  alarm_pin_select;
    wire                  stop_release_pin_select;
    wire                  event_count_pin_select;
    wire                  ext_irq1_pin_select;
    wire                  ext_irq0_pin_select;
    reg                   alarm_hold;
    wire                  alarm_level;
    reg  [`NUM_PINS-1:0]  next_pin_out;

    assign in_stop    = (power_mode == `PWR_STOP);
    assign in_standby = (power_mode == `PWR_STANDBY);

    mode_regs u_mode_regs (
        .mclk             (mclk),
        .arst_n           (arst_n),
        .stop_clear       (in_stop),
        .reg_wr           (reg_wr),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .port_mode_a      (port_mode_a),
        .port_mode_b      (port_mode_b),
        .misc_pin_control (misc_pin_control)
    );

    // Set and clear are masked in standby, so latch updates cannot occur there
    bit_latch_file u_latches (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .stop_clear (in_stop),
        .set_req    (bit_set_op & ~in_standby),
        .clear_req  (bit_clear_op & ~in_standby),
        .pin_sel    (pin_index),
        .latch      (output_latch)
    );

    assign alarm_pin_select        = port_mode_a[`ALARM_SEL_BIT];
    assign stop_release_pin_select = port_mode_b[`STOP_REL_SEL_BIT];
    assign event_count_pin_select  = port_mode_b[`EVENT_SEL_BIT];
    assign ext_irq1_pin_select     = port_mode_b[`IRQ1_SEL_BIT];
    assign ext_irq0_pin_select     = port_mode_b[`IRQ0_SEL_BIT];
    assign pullup_enable           = misc_pin_control[`PULLUP_EN_BIT];
    assign serial_out_open_drain_sel = misc_pin_control[`SO_OD_SEL_BIT];

    assign halt_n = ~in_stop;

    // Alarm level frozen in standby unless its source keeps running
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_hold <= 1'b0;
        end else if (!in_standby || alarm_runs_in_standby) begin
            alarm_hold <= alarm_out;
        end
    end
    assign alarm_level = (in_standby && !alarm_runs_in_standby) ?
                         alarm_hold : alarm_out;

    // Pin drive: high-side only, so a 0 leaves the pin floating
    always @* begin
        next_pin_out = output_latch;
        if (alarm_pin_select) begin
            next_pin_out[`PIN_ALARM] = alarm_level;
        end
    end

    assign pin_out = next_pin_out;
    assign pin_oe  = halt_n ? next_pin_out : {`NUM_PINS{1'b0}};

    // Shared irq inputs idle high when not routed; timer event input idles low
    assign ext_irq0_n = ext_irq0_pin_select ?
                        pin_in[`PIN_IRQ0] : 1'b1;
    assign ext_irq1_n = ext_irq1_pin_select ?
                        pin_in[`PIN_IRQ1] : 1'b1;
    assign timer_b_event_in = event_count_pin_select ?
                              pin_in[`PIN_EVENT] : 1'b0;
    // Stop release is not gated by halt; stop clears port_mode_b at the first clock edge in stop, so it reads 1 from that edge on while halted
    assign stop_release_n = stop_release_pin_select ?
                            pin_in[`PIN_STOP_REL] : 1'b1;

    assign std_pullup_on = (pullup_enable && halt_n) ?
                           std_pin_latch : {`NUM_PINS{1'b0}};

    assign serial_out_high_on = halt_n && serial_out_data &&
                                !serial_out_open_drain_sel;
    assign serial_out_low_on  = halt_n && !serial_out_data;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_test_result <= 1'b0;
        end else if (bit_test_op && pin_index < `NUM_PINS) begin
            bit_test_result <= pin_in[pin_index];
        end
    end

endmodule // high_voltage_bit_port_ctrl

// file: port_ctrl_chk.sv
`timescale 1ns/1ps
`include "hv_port_defines.vh"
module port_ctrl_chk (
    // Clock and reset
    input wire                  mclk,
    input wire                  arst_n,
    // Controls
    input wire [`PWR_W-1:0]     power_mode,
    input wire                  bit_set_op,
    input wire                  bit_clear_op,
    input wire [`PIN_IDX_W-1:0] pin_index,
    input wire                  serial_out_data,
    input wire [`NUM_PINS-1:0]  std_pin_latch,
    // Observed
    input wire [`NUM_PINS-1:0]  pin_out,
    input wire [`NUM_PINS-1:0]  pin_oe,
    input wire [`NUM_PINS-1:0]  std_pullup_on,
    input wire                  serial_out_high_on,
    input wire                  serial_out_open_drain_sel,
    input wire                  pullup_enable,
    input wire                  halt_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_pullup_off: assert property (
        !pullup_enable |-> std_pullup_on == 9'h000) else $error("pull-up on");
    chk_pullup_follow: assert property (
        pullup_enable && halt_n |-> std_pullup_on == std_pin_latch)
        else $error("pull-up pattern wrong");
    chk_push_pull: assert property (
        halt_n && !serial_out_open_drain_sel && serial_out_data
        |-> serial_out_high_on) else $error("high side off");
    chk_open_drain: assert property (
        serial_out_open_drain_sel |-> !serial_out_high_on)
        else $error("high side on");
    chk_stop_float: assert property (
        power_mode == 2'h2 |-> !halt_n && pin_oe == 9'h000
        && std_pullup_on == 9'h000) else $error("stop not floating");
    chk_halt_high: assert property (
        power_mode != 2'h2 |-> halt_n) else $error("halt low");
    chk_standby_hold: assert property (
        power_mode == 2'h1 && $past(power_mode) == 2'h1
        |-> $stable(pin_out[8:4])) else $error("standby output moved");
    chk_set_latch: assert property (
        bit_set_op && power_mode == 2'h0 && pin_index > 4 && pin_index < 9
        |=> power_mode == 2'h2 || pin_out[$past(pin_index)])
        else $error("set lost");
    chk_clear_latch: assert property (
        bit_clear_op && !bit_set_op && power_mode == 2'h0 && pin_index > 4
        && pin_index < 9 |=> !pin_out[$past(pin_index)])
        else $error("clear lost");
    chk_drive_high: assert property (
        halt_n |-> pin_oe == pin_out) else $error("drive pattern wrong");
endmodule // port_ctrl_chk
bind high_voltage_bit_port_ctrl port_ctrl_chk u_chk (.mclk, .arst_n,
    .power_mode, .bit_set_op, .bit_clear_op, .pin_index, .serial_out_data,
    .std_pin_latch, .pin_out, .pin_oe, .std_pullup_on, .serial_out_high_on,
    .serial_out_open_drain_sel, .pullup_enable, .halt_n);

// file: ext_pin_load.sv
`timescale 1ns/1ps
// External source per pin; it only drives where the port leaves it undriven
module ext_pin_load (
    // Port side
    input  wire [8:0] pin_out,
    input  wire [8:0] pin_oe,
    // Outside world
    input  wire [8:0] ext_level,
    output wire [8:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // ext_pin_load

// file: test_high_voltage_bit_port_ctrl.sv
`timescale 1ns/1ps
`include "hv_port_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_high_voltage_bit_port_ctrl;
    reg       mclk = 0, arst_n = 0, bs = 0, bc = 0, bt = 0, wr = 0;
    reg       alm = 0, sod = 0, ars = 0, s;
    reg [1:0] pm = 0;
    reg [3:0] idx = 0, wd = 0;
    reg [5:0] ad = 0;
    reg [8:0] ext = 0, sl = 9'h1ff, exp_l = 0;
    wire [8:0] pin_in, pin_out, pin_oe, spu;
    wire      tr, i0, i1, ev, sr, sh, slo, hn, pe, od;
    int       n_errors = 0, checked = 0, k;
    high_voltage_bit_port_ctrl u_dut (.mclk(mclk), .arst_n(arst_n),
        .power_mode(pm), .bit_set_op(bs), .bit_clear_op(bc),
        .bit_test_op(bt), .pin_index(idx), .bit_test_result(tr),
        .reg_wr(wr), .reg_addr(ad), .reg_wdata(wd), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alarm_out(alm),
        .alarm_runs_in_standby(ars), .ext_irq0_n(i0), .ext_irq1_n(i1),
        .timer_b_event_in(ev), .stop_release_n(sr), .std_pin_latch(sl),
        .std_pullup_on(spu), .serial_out_data(sod),
        .serial_out_high_on(sh), .serial_out_low_on(slo), .halt_n(hn),
        .pullup_enable(pe), .serial_out_open_drain_sel(od));
    ext_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));
    function automatic logic lvl(input [8:0] l, input [8:0] e, input int i);
        lvl = l[i] | e[i];
    endfunction
    task cyc(input int i, input a, input b, input t);
        @(negedge mclk) begin idx = i; bs = a; bc = b; bt = t; end
        @(negedge mclk) begin bs = 0; bc = 0; bt = 0; end
    endtask
    task wreg(input [5:0] a, input [3:0] d);
        @(negedge mclk) begin ad = a; wd = d; wr = 1; end
        @(negedge mclk) wr = 0;
    endtask
    task end_sim;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        forever #50 mclk = ~mclk;
    end
    initial begin
        k = $urandom(32'h152d);
        repeat (16) @(posedge mclk);
        @(negedge mclk) arst_n = 1;
        `CHK("oe_rst", 9'h000, pin_oe)
        `CHK("irq0_rst", 1'b1, i0)
        `CHK("pu_rst", 9'h000, spu)
        repeat (60) begin
            k = $urandom % 9;
            s = $urandom;
            cyc(k, s, !s, 0);
            exp_l[k] = s;
            `CHK("pin_out", exp_l, pin_out)
            `CHK("pin_oe", exp_l, pin_oe)
            ext = $urandom & ~exp_l;
            k = $urandom % 9;
            cyc(k, 0, 0, 1);
            `CHK("test", lvl(exp_l, ext, k), tr)
        end
        // A test of an index past the port keeps the last result
        cyc(12, 0, 0, 1);
        `CHK("test_oob", lvl(exp_l, ext, k), tr)
        // Set beats clear; index past the port is ignored
        cyc(7, 1, 1, 0);
        cyc(9, 1, 0, 0);
        exp_l[7] = 1;
        `CHK("both_ops", exp_l, pin_out)
        for (k = 0; k < 5; k++) cyc(k, 0, 1, 0);
        exp_l[4:0] = 0;
        wreg(6'h24, 4'hf);
        wreg(6'h3f, 4'h0);
        for (k = 0; k < 4; k++) begin
            @(negedge mclk) ext = $urandom & 9'h01f;
            #1 `CHK("irq0", ext[0], i0)
            `CHK("irq1", ext[1], i1)
            `CHK("event", ext[2], ev)
            `CHK("stop_rel", ext[4], sr)
        end
        wreg(6'h04, 4'h8);
        for (k = 0; k < 2; k++) begin
            @(negedge mclk) alm = !alm;
            #1 `CHK("alarm", alm, pin_out[3])
        end
        @(negedge mclk) sod = 1;
        #1 `CHK("pp_high", 1'b1, sh)
        @(negedge mclk) sl = $urandom;
        wreg(6'h0c, 4'hc);
        `CHK("pullup", sl, spu)
        `CHK("od_high", 1'b0, sh)
        `CHK("od_sel", 1'b1, od)
        @(negedge mclk) sod = 0;
        #1 `CHK("od_low", 1'b1, slo)
        @(negedge mclk) pm = 2'h1;
        cyc(8, !exp_l[8], exp_l[8], 0);
        `CHK("standby", exp_l[8:4], pin_out[8:4])
        `CHK("halt_sb", 1'b1, hn)
        // Stopped alarm source freezes, a running one keeps driving
        @(negedge mclk) alm = !alm;
        #1 `CHK("alarm_frz", !alm, pin_out[3])
        @(negedge mclk) ars = 1;
        #1 `CHK("alarm_run", alm, pin_out[3])
        @(negedge mclk) pm = 2'h2;
        #1 `CHK("halt_stop", 1'b0, hn)
        `CHK("oe_stop", 9'h000, pin_oe)
        `CHK("pu_stop", 9'h000, spu)
        @(negedge mclk) pm = 2'h0;
        @(negedge mclk);
        `CHK("latch_stop", 9'h000, pin_out)
        `CHK("pe_stop", 1'b0, pe)
        `CHK("irq0_stop", 1'b1, i0)
        end_sim;
    end
endmodule // test_high_voltage_bit_port_ctrl
